//--- dbc_pkg.sv
// shared constants, tables and types for both des block cipher ends
package dbc_pkg;

	// datapath widths and round bookkeeping
	localparam int          DBC_BLK_W    = 64;
	localparam int          DBC_HALF_W   = 32;
	localparam int          DBC_CD_W     = 28;
	localparam int          DBC_SUB_W    = 48;
	localparam logic [3:0]  DBC_RND_RST  = 4'h0;
	localparam logic [3:0]  DBC_LAST_RND = 4'hF;
	localparam logic [15:0] DBC_SHIFT2   = 16'h7EFC; // set bit: that round rotates by two
	localparam logic [63:0] DBC_DATA_RST = 64'h0;

	// apb register byte offsets of the controller end
	localparam logic [7:0] DBC_A_KEY_HI  = 8'h00;
	localparam logic [7:0] DBC_A_KEY_LO  = 8'h04;
	localparam logic [7:0] DBC_A_DIN_HI  = 8'h08;
	localparam logic [7:0] DBC_A_DIN_LO  = 8'h0C;
	localparam logic [7:0] DBC_A_CTRL    = 8'h10;
	localparam logic [7:0] DBC_A_CMD     = 8'h14;
	localparam logic [7:0] DBC_A_STAT    = 8'h18;
	localparam logic [7:0] DBC_A_DOUT_HI = 8'h1C;
	localparam logic [7:0] DBC_A_DOUT_LO = 8'h20;

	// field positions
	localparam int         DBC_CTRL_DIR  = 0;
	localparam int         DBC_CTRL_PAR  = 1;
	localparam int         DBC_CTRL_HOLD = 2;
	localparam int         DBC_CMD_START = 0;
	localparam int         DBC_CMD_ABORT = 1;
	localparam int         DBC_STAT_DONE = 1;
	localparam logic [2:0] DBC_CTRL_RST  = 3'h1; // encrypt, parity off, no hold

	typedef enum logic [1:0] {
		DBC_IDLE = 2'b00,
		DBC_RUN  = 2'b01
	} dbc_state_t;

	// bit tables, 1 is the most significant bit of a bus
	localparam byte unsigned DBC_IP [64] = '{58, 50, 42, 34, 26, 18, 10, 2, 60, 52, 44, 36,
		28, 20, 12, 4, 62, 54, 46, 38, 30, 22, 14, 6, 64, 56, 48, 40, 32, 24, 16, 8, 57, 49,
		41, 33, 25, 17, 9, 1, 59, 51, 43, 35, 27, 19, 11, 3, 61, 53, 45, 37, 29, 21, 13, 5,
		63, 55, 47, 39, 31, 23, 15, 7};
	localparam byte unsigned DBC_FP [64] = '{40, 8, 48, 16, 56, 24, 64, 32, 39, 7, 47, 15,
		55, 23, 63, 31, 38, 6, 46, 14, 54, 22, 62, 30, 37, 5, 45, 13, 53, 21, 61, 29, 36, 4,
		44, 12, 52, 20, 60, 28, 35, 3, 43, 11, 51, 19, 59, 27, 34, 2, 42, 10, 50, 18, 58, 26,
		33, 1, 41, 9, 49, 17, 57, 25};
	localparam byte unsigned DBC_E [48] = '{32, 1, 2, 3, 4, 5, 4, 5, 6, 7, 8, 9, 8, 9, 10,
		11, 12, 13, 12, 13, 14, 15, 16, 17, 16, 17, 18, 19, 20, 21, 20, 21, 22, 23, 24, 25,
		24, 25, 26, 27, 28, 29, 28, 29, 30, 31, 32, 1};
	localparam byte unsigned DBC_P [32] = '{16, 7, 20, 21, 29, 12, 28, 17, 1, 15, 23, 26, 5,
		18, 31, 10, 2, 8, 24, 14, 32, 27, 3, 9, 19, 13, 30, 6, 22, 11, 4, 25};
	localparam byte unsigned DBC_PC1 [56] = '{57, 49, 41, 33, 25, 17, 9, 1, 58, 50, 42, 34,
		26, 18, 10, 2, 59, 51, 43, 35, 27, 19, 11, 3, 60, 52, 44, 36, 63, 55, 47, 39, 31, 23,
		15, 7, 62, 54, 46, 38, 30, 22, 14, 6, 61, 53, 45, 37, 29, 21, 13, 5, 28, 20, 12, 4};
	localparam byte unsigned DBC_PC2 [48] = '{14, 17, 11, 24, 1, 5, 3, 28, 15, 6, 21, 10, 23,
		19, 12, 4, 26, 8, 16, 7, 27, 20, 13, 2, 41, 52, 31, 37, 47, 55, 30, 40, 51, 45, 33,
		48, 44, 49, 39, 56, 34, 53, 46, 42, 50, 36, 29, 32};

	// substitution boxes, entry 0 in the top nibble, index {row, column}
	localparam logic [255:0] DBC_SBOX [8] = '{
		256'hE4D12FB83A6C59070F74E2D1A6CB953841E8D62BFC973A50FC8249175B3EA06D,
		256'hF18E6B34972DC05A3D47F28EC01A69B50E7BA4D158C6932FD8A13F42B67C05E9,
		256'hA09E63F51DC7B428D709346A285ECBF1D6498F30B12C5AE71AD069874FE3B52C,
		256'h7DE3069A1285BC4FD8B56F03472C1AE9A690CB7DF13E52843F06A1D8945BC72E,
		256'h2C417AB6853FD0E9EB2C47D150FA3986421BAD78F9C5630EB8C71E2D6F09A453,
		256'hC1AF92680D34E75BAF427C9561DE0B389EF528C3704A1DB6432C95FABE17608D,
		256'h4B2EF08D3C975A61D0B7491AE35C2F8614BDC37EAF6805926BD814A7950FE23C,
		256'hD2846FB1A93E50C71FD8A374C56B0E927B419CE206ADF35821E74A8DFC90356B};

endpackage : dbc_pkg

//--- dbc_link_if.sv
// link between the cipher core and the controller that feeds it
`timescale 1ns/1ps
interface dbc_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	logic [63:0] key;
	logic [63:0] block_in;
	logic [63:0] result;
	logic        direction_select;
	logic        advance_gate;
	logic        abort_request;
	logic        parity_test_on;
	logic        result_valid;
	logic        parity_fault;

	modport dev (
		input  pclk,
		input  presetn,
		input  key,
		input  block_in,
		input  direction_select,
		input  advance_gate,
		input  abort_request,
		input  parity_test_on,
		output result,
		output result_valid,
		output parity_fault
	);

	modport usr (
		input  pclk,
		input  presetn,
		output key,
		output block_in,
		output direction_select,
		output advance_gate,
		output abort_request,
		output parity_test_on,
		input  result,
		input  result_valid,
		input  parity_fault
	);
endinterface : dbc_link_if

//--- dbc_round.sv
// one feistel round: expansion, key mix, substitution, permutation
`timescale 1ns/1ps
module dbc_round (
	input  wire logic [31:0] l_in,
	input  wire logic [31:0] r_in,
	input  wire logic [47:0] subkey,
	output logic      [31:0] l_out,
	output logic      [31:0] r_out
);
	logic [47:0] mixed;
	logic [31:0] sout;
	logic [31:0] fout;

	// expand the right half and mix in the round key
	always_comb begin
		for (int i = 0; i < dbc_pkg::DBC_SUB_W; i++) begin
			mixed[47 - i] = r_in[32 - int'(dbc_pkg::DBC_E[i])] ^ subkey[47 - i];
		end
	end

	// eight table lookups, six bits in and four bits out each
	for (genvar g = 0; g < 8; g++) begin : g_sbox
		logic [5:0] six;
		logic [5:0] idx;
		assign six = mixed[47 - 6 * g -: 6];
		assign idx = {six[5], six[0], six[4:1]};
		assign sout[31 - 4 * g -: 4] = dbc_pkg::DBC_SBOX[g][255 - 4 * int'(idx) -: 4];
	end

	// straight permutation, then swap halves
	always_comb begin
		for (int i = 0; i < dbc_pkg::DBC_HALF_W; i++) begin
			fout[31 - i] = sout[32 - int'(dbc_pkg::DBC_P[i])];
		end
		l_out = r_in;
		r_out = l_in ^ fout;
	end
endmodule : dbc_round

//--- dbc_core.sv
// iterative des cipher core, one round per gated clock
`timescale 1ns/1ps
module dbc_core (
	dbc_link_if.dev link
);
	dbc_pkg::dbc_state_t st_q;
	dbc_pkg::dbc_state_t st_d;
	logic [3:0]          rnd_q;
	logic [3:0]          rnd_d;
	logic                dir_q;
	logic                dir_d;
	logic [27:0]         c_q;
	logic [27:0]         c_d;
	logic [27:0]         d_q;
	logic [27:0]         d_d;
	logic [31:0]         l_q;
	logic [31:0]         l_d;
	logic [31:0]         r_q;
	logic [31:0]         r_d;
	logic [63:0]         res_q;
	logic [63:0]         res_d;
	logic                val_q;
	logic                val_d;
	logic                pf_q;
	logic                pf_d;

	logic                loading;
	logic                dir_use;
	logic [3:0]          rnd_use;
	logic [1:0]          rot;
	logic [55:0]         cd_src;
	logic [63:0]         lr_src;
	logic [27:0]         c_rot;
	logic [27:0]         d_rot;
	logic [47:0]         subkey;
	logic [31:0]         l_new;
	logic [31:0]         r_new;
	logic [7:0]          byte_bad;

	// key reduction; the table never names bits 8, 16 .. 64
	function automatic logic [55:0] dbc_pc1(input logic [63:0] k);
		logic [55:0] o;
		for (int i = 0; i < 56; i++) begin
			o[55 - i] = k[64 - int'(dbc_pkg::DBC_PC1[i])];
		end
		return o;
	endfunction : dbc_pc1

	// round key selection from the rotated halves
	function automatic logic [47:0] dbc_pc2(input logic [55:0] cd);
		logic [47:0] o;
		for (int i = 0; i < dbc_pkg::DBC_SUB_W; i++) begin
			o[47 - i] = cd[56 - int'(dbc_pkg::DBC_PC2[i])];
		end
		return o;
	endfunction : dbc_pc2

	// initial permutation of the incoming block
	function automatic logic [63:0] dbc_ip(input logic [63:0] x);
		logic [63:0] o;
		for (int i = 0; i < dbc_pkg::DBC_BLK_W; i++) begin
			o[63 - i] = x[64 - int'(dbc_pkg::DBC_IP[i])];
		end
		return o;
	endfunction : dbc_ip

	// final permutation, inverse of the initial one
	function automatic logic [63:0] dbc_fp(input logic [63:0] x);
		logic [63:0] o;
		for (int i = 0; i < dbc_pkg::DBC_BLK_W; i++) begin
			o[63 - i] = x[64 - int'(dbc_pkg::DBC_FP[i])];
		end
		return o;
	endfunction : dbc_fp

	// rotate a key half by 0, 1 or 2 places
	function automatic logic [27:0] dbc_rot(input logic [27:0] x, input logic left,
		input logic [1:0] n);
		logic [27:0] o;
		o = x;
		if (n == 2'd1) begin
			o = left ? {x[26:0], x[27]} : {x[0], x[27:1]};
		end else if (n == 2'd2) begin
			o = left ? {x[25:0], x[27:26]} : {x[1:0], x[27:2]};
		end
		return o;
	endfunction : dbc_rot

	// a gated idle cycle takes fresh key and block, later ones use the schedules
	always_comb begin
		loading = (st_q == dbc_pkg::DBC_IDLE);
		cd_src  = loading ? dbc_pc1(link.key) : {c_q, d_q};
		lr_src  = loading ? dbc_ip(link.block_in) : {l_q, r_q};
		dir_use = loading ? link.direction_select : dir_q;
		rnd_use = loading ? dbc_pkg::DBC_RND_RST : rnd_q;
	end

	// encrypt rotates left before each round; decrypt walks the keys backwards by
	// rotating right, with no rotation before the first round
	always_comb begin
		if (dir_use) begin
			rot = dbc_pkg::DBC_SHIFT2[rnd_use] ? 2'd2 : 2'd1;
		end else if (rnd_use == dbc_pkg::DBC_RND_RST) begin
			rot = 2'd0;
		end else begin
			rot = dbc_pkg::DBC_SHIFT2[4'(5'd16 - {1'b0, rnd_use})] ? 2'd2 : 2'd1;
		end
		c_rot  = dbc_rot(cd_src[55:28], dir_use, rot);
		d_rot  = dbc_rot(cd_src[27:0], dir_use, rot);
		subkey = dbc_pc2({c_rot, d_rot});
	end

	dbc_round u_round (
		.l_in   (lr_src[63:32]),
		.r_in   (lr_src[31:0]),
		.subkey (subkey),
		.l_out  (l_new),
		.r_out  (r_new)
	);

	// round sequencing: abort wins, a low gate holds everything but the pulse
	always_comb begin
		st_d  = st_q;
		rnd_d = rnd_q;
		dir_d = dir_q;
		c_d   = c_q;
		d_d   = d_q;
		l_d   = l_q;
		r_d   = r_q;
		res_d = res_q;
		val_d = 1'b0; // one cycle pulse only
		if (link.abort_request) begin
			st_d  = dbc_pkg::DBC_IDLE;
			rnd_d = dbc_pkg::DBC_RND_RST;
			c_d   = '0;
			d_d   = '0;
			l_d   = '0;
			r_d   = '0;
		end else if (link.advance_gate) begin
			dir_d = dir_use; // latched at load, the core keeps it steady
			c_d   = c_rot;
			d_d   = d_rot;
			l_d   = l_new;
			r_d   = r_new;
			case (st_q)
				dbc_pkg::DBC_IDLE: begin
					st_d  = dbc_pkg::DBC_RUN;
					rnd_d = 4'h1;
				end
				dbc_pkg::DBC_RUN: begin
					if (rnd_q == dbc_pkg::DBC_LAST_RND) begin
						st_d  = dbc_pkg::DBC_IDLE; // next gated cycle loads again
						rnd_d = dbc_pkg::DBC_RND_RST;
						res_d = dbc_fp({r_new, l_new});
						val_d = 1'b1;
					end else begin
						rnd_d = rnd_q + 4'h1;
					end
				end
				default: begin
					st_d  = dbc_pkg::DBC_IDLE;
					rnd_d = dbc_pkg::DBC_RND_RST;
				end
			endcase
		end
		// gate low: all schedules hold, same path for either direction
	end

	// per byte odd parity test over all eight key bytes
	for (genvar g = 0; g < 8; g++) begin : g_par
		assign byte_bad[g] = ~^link.key[8 * g +: 8];
	end

	// fault follows the key every cycle, forced low when checking is off
	always_comb begin
		pf_d = link.parity_test_on & (|byte_bad);
	end

	// state registers, asynchronous reset to constants only
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			st_q  <= dbc_pkg::DBC_IDLE;
			rnd_q <= dbc_pkg::DBC_RND_RST;
			dir_q <= 1'b0;
			c_q   <= '0;
			d_q   <= '0;
			l_q   <= '0;
			r_q   <= '0;
			res_q <= dbc_pkg::DBC_DATA_RST;
			val_q <= 1'b0;
			pf_q  <= 1'b0;
		end else begin
			st_q  <= st_d;
			rnd_q <= rnd_d;
			dir_q <= dir_d;
			c_q   <= c_d;
			d_q   <= d_d;
			l_q   <= l_d;
			r_q   <= r_d;
			res_q <= res_d;
			val_q <= val_d;
			pf_q  <= pf_d;
		end
	end

	// result holds until the next block finishes; valid marks the one fresh cycle
	assign link.result       = res_q;
	assign link.result_valid = val_q;
	assign link.parity_fault = pf_q;

endmodule : dbc_core

//--- dbc_user.sv
// controller end: apb registers that feed the core and collect results
`timescale 1ns/1ps
module dbc_user (
	dbc_link_if.usr     link,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	dbc_pkg::dbc_state_t st_q;
	dbc_pkg::dbc_state_t st_d;
	logic [63:0]         key_q;
	logic [63:0]         key_d;
	logic [63:0]         din_q;
	logic [63:0]         din_d;
	logic [63:0]         dout_q;
	logic [63:0]         dout_d;
	logic [2:0]          ctrl_q;
	logic [2:0]          ctrl_d;
	logic [3:0]          cnt_q;
	logic [3:0]          cnt_d;
	logic                pend_q;
	logic                pend_d;
	logic                gate_q;
	logic                gate_d;
	logic                abort_q;
	logic                abort_d;
	logic                done_q;
	logic                done_d;
	logic                pf_q;
	logic [31:0]         rd_q;
	logic [31:0]         rd_d;
	logic                rdy_q;
	logic                err_q;
	logic                err_d;
	logic                wr;
	logic                start_wr;
	logic                hold;

	// a write lands at the access edge; reads are staged in setup
	always_comb begin
		wr       = psel & penable & pwrite & rdy_q;
		start_wr = wr & (paddr == dbc_pkg::DBC_A_CMD) & pwdata[dbc_pkg::DBC_CMD_START];
		hold     = ctrl_q[dbc_pkg::DBC_CTRL_HOLD];
		key_d    = key_q;
		din_d    = din_q;
		ctrl_d   = ctrl_q;
		if (wr) begin
			case (paddr)
				dbc_pkg::DBC_A_KEY_HI: key_d[63:32] = pwdata;
				dbc_pkg::DBC_A_KEY_LO: key_d[31:0]  = pwdata;
				dbc_pkg::DBC_A_DIN_HI: din_d[63:32] = pwdata;
				dbc_pkg::DBC_A_DIN_LO: din_d[31:0]  = pwdata;
				dbc_pkg::DBC_A_CTRL:   ctrl_d       = pwdata[2:0];
				default:               ctrl_d       = ctrl_q;
			endcase
		end
		err_d = 1'b0;
		case (paddr)
			dbc_pkg::DBC_A_KEY_HI:  rd_d = key_q[63:32];
			dbc_pkg::DBC_A_KEY_LO:  rd_d = key_q[31:0];
			dbc_pkg::DBC_A_DIN_HI:  rd_d = din_q[63:32];
			dbc_pkg::DBC_A_DIN_LO:  rd_d = din_q[31:0];
			dbc_pkg::DBC_A_CTRL:    rd_d = {29'h0, ctrl_q};
			dbc_pkg::DBC_A_CMD:     rd_d = 32'h0;
			dbc_pkg::DBC_A_STAT:    rd_d = {28'h0, pend_q, pf_q, done_q, gate_q | abort_q};
			dbc_pkg::DBC_A_DOUT_HI: rd_d = dout_q[63:32];
			dbc_pkg::DBC_A_DOUT_LO: rd_d = dout_q[31:0];
			default: begin
				rd_d  = 32'h0;
				err_d = 1'b1; // unmapped address
			end
		endcase
	end

	// block sequencer: counts gated cycles in step with the core, so a queued
	// block is loaded exactly on the core's loading edge
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		gate_d  = gate_q;
		pend_d  = pend_q;
		abort_d = 1'b0;
		if (wr && (paddr == dbc_pkg::DBC_A_CMD) && pwdata[dbc_pkg::DBC_CMD_ABORT]) begin
			abort_d = 1'b1; // one cycle abort
			st_d    = dbc_pkg::DBC_IDLE;
			cnt_d   = dbc_pkg::DBC_RND_RST;
			gate_d  = 1'b0;
			pend_d  = 1'b0;
		end else begin
			case (st_q)
				dbc_pkg::DBC_IDLE: begin
					if (pend_q) begin
						st_d   = dbc_pkg::DBC_RUN;
						pend_d = 1'b0;
						cnt_d  = dbc_pkg::DBC_RND_RST;
						gate_d = ~hold;
					end
				end
				dbc_pkg::DBC_RUN: begin
					gate_d = ~hold; // sink full pauses the core
					if (gate_q) begin
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == dbc_pkg::DBC_LAST_RND) begin
							if (pend_q) begin
								pend_d = 1'b0; // next block, back to back
							end else begin
								st_d   = dbc_pkg::DBC_IDLE; // stop after the last
								gate_d = 1'b0;
							end
						end
					end
				end
				default: begin
					st_d   = dbc_pkg::DBC_IDLE;
					gate_d = 1'b0;
				end
			endcase
			pend_d = pend_d | start_wr; // a new start beats consumption
		end
		done_d = (done_q & ~(wr & (paddr == dbc_pkg::DBC_A_STAT) &
			pwdata[dbc_pkg::DBC_STAT_DONE])) | link.result_valid; // set beats clear
		dout_d = link.result_valid ? link.result : dout_q;
	end

	// registers; reset values are constants only
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			st_q    <= dbc_pkg::DBC_IDLE;
			key_q   <= dbc_pkg::DBC_DATA_RST;
			din_q   <= dbc_pkg::DBC_DATA_RST;
			dout_q  <= dbc_pkg::DBC_DATA_RST;
			ctrl_q  <= dbc_pkg::DBC_CTRL_RST;
			cnt_q   <= dbc_pkg::DBC_RND_RST;
			pend_q  <= 1'b0;
			gate_q  <= 1'b0;
			abort_q <= 1'b0;
			done_q  <= 1'b0;
			pf_q    <= 1'b0;
			rd_q    <= 32'h0;
			rdy_q   <= 1'b0;
			err_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			key_q   <= key_d;
			din_q   <= din_d;
			dout_q  <= dout_d;
			ctrl_q  <= ctrl_d;
			cnt_q   <= cnt_d;
			pend_q  <= pend_d;
			gate_q  <= gate_d;
			abort_q <= abort_d;
			done_q  <= done_d;
			pf_q    <= link.parity_fault;
			rd_q    <= (psel & ~penable) ? rd_d : rd_q;
			rdy_q   <= psel & ~penable; // zero wait state access
			err_q   <= psel & ~penable & err_d;
		end
	end

	// the cipher path samples key and block only on the core's loading edge, so the staging
	// registers drive the link directly
	assign link.key              = key_q;
	assign link.block_in         = din_q;
	assign link.direction_select = ctrl_q[dbc_pkg::DBC_CTRL_DIR];
	assign link.parity_test_on   = ctrl_q[dbc_pkg::DBC_CTRL_PAR];
	assign link.advance_gate     = gate_q;
	assign link.abort_request    = abort_q;
	assign prdata                = rd_q;
	assign pready                = rdy_q;
	assign pslverr               = err_q;

endmodule : dbc_user

//--- dbc_link_props.sv
// concurrent checks on the link between the cipher core and its controller
`timescale 1ns/1ps
module dbc_link_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [63:0] key,
	input wire logic [63:0] result,
	input wire logic        advance_gate,
	input wire logic        abort_request,
	input wire logic        parity_test_on,
	input wire logic        result_valid,
	input wire logic        parity_fault
);
	logic       key_bad;
	logic [4:0] rnd_d;
	logic [4:0] rnd_q;
	logic       fin_d;
	logic       fin_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// any key byte with an even count of ones
	always_comb begin
		key_bad = 1'b0;
		for (int i = 0; i < 8; i++) begin
			key_bad = key_bad | ~^key[8*i +: 8];
		end
	end

	// reference round count; 0 and 16 both mean idle, abort wins over gate
	always_comb begin
		rnd_d = rnd_q;
		fin_d = 1'b0;
		if (abort_request) begin
			rnd_d = 5'h00;
		end else if (advance_gate) begin
			rnd_d = (rnd_q == 5'h00 || rnd_q == 5'h10) ? 5'h01 : rnd_q + 5'h01;
			fin_d = (rnd_q == 5'h0F);
		end
	end

	// register the reference count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rnd_q <= 5'h00;
			fin_q <= 1'b0;
		end else begin
			rnd_q <= rnd_d;
			fin_q <= fin_d;
		end
	end

	sequence s_round;
		advance_gate && !abort_request;
	endsequence
	sequence s_pulse;
		result_valid ##1 !result_valid;
	endsequence
	sequence s_gated_edge;
		$past(advance_gate) && !$past(abort_request);
	endsequence
	sequence s_fault_follows;
		parity_fault == $past(key_bad);
	endsequence

	a_valid_pulse: assert property (result_valid |-> s_pulse)
		else $error("result valid longer than one cycle");
	a_round_count: assert property (result_valid == fin_q)
		else $error("result valid not after sixteen gated rounds");
	a_gate_freeze: assert property (!advance_gate |=> !result_valid)
		else $error("result appeared while gate was low");
	a_valid_cause: assert property (result_valid |-> s_gated_edge)
		else $error("result without a gated edge before it");
	a_abort_drops: assert property (abort_request |=> !result_valid)
		else $error("aborted block still gave a result");
	a_result_holds: assert property (!result_valid |-> $stable(result))
		else $error("result changed without valid");
	a_parity_off: assert property (!parity_test_on |=> !parity_fault)
		else $error("parity fault while checking off");
	a_parity_match: assert property (parity_test_on |=> s_fault_follows)
		else $error("parity fault does not match key bytes");

	// long gated stretch seen
	c_gated_run: cover property (s_round [*8]);
endmodule : dbc_link_props

//--- tb_des_block_cipher.sv
// apb driven test of the des controller and core joined by their link
`timescale 1ns/1ps
module tb_des_block_cipher;
	localparam logic [63:0] KEY    = 64'h133457799BBCDFF1;
	localparam logic [63:0] KEY_BP = 64'h123457799BBCDFF1; // top byte parity bit flipped
	localparam logic [63:0] PT     = 64'h0123456789ABCDEF;
	localparam logic [63:0] CT     = 64'h85E813540F0AB405;

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        se;
	logic [63:0] q;
	int          err_count = 0;
	int          n_tests   = 0;
	int          n_res     = 0;
	int          n_base;

	// 200 MHz
	always #2.5 pclk = ~pclk;

	// count result pulses on the link, so back to back blocks can be told apart
	always @(posedge pclk) begin
		if (i_dbc_link_if.result_valid === 1'b1) begin
			n_res <= n_res + 1;
		end
	end

	dbc_link_if i_dbc_link_if (.pclk(pclk), .presetn(presetn));
	dbc_core i_dbc_core (.link(i_dbc_link_if));
	dbc_user i_dbc_user (.link(i_dbc_link_if), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	dbc_link_props i_dbc_link_props (.pclk(pclk), .presetn(presetn), .key(i_dbc_link_if.key),
		.result(i_dbc_link_if.result), .advance_gate(i_dbc_link_if.advance_gate),
		.abort_request(i_dbc_link_if.abort_request),
		.parity_test_on(i_dbc_link_if.parity_test_on),
		.result_valid(i_dbc_link_if.result_valid), .parity_fault(i_dbc_link_if.parity_fault));

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; idle cycle after it so psel never toggles twice in a step
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) begin
			err_count++;
		end
		rd = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer

	// load one block, start it, optionally hold it mid-run, collect the result
	task automatic run(input logic [63:0] k, input logic [63:0] din, input logic [2:0] ctl,
		input bit pause, output logic [63:0] res);
		xfer(1'b1, dbc_pkg::DBC_A_KEY_HI, k[63:32]);
		xfer(1'b1, dbc_pkg::DBC_A_KEY_LO, k[31:0]);
		xfer(1'b1, dbc_pkg::DBC_A_DIN_HI, din[63:32]);
		xfer(1'b1, dbc_pkg::DBC_A_DIN_LO, din[31:0]);
		xfer(1'b1, dbc_pkg::DBC_A_CTRL, {29'h0, ctl});
		xfer(1'b1, dbc_pkg::DBC_A_STAT, 32'h2);
		xfer(1'b1, dbc_pkg::DBC_A_CMD, 32'h1);
		if (pause) begin
			xfer(1'b1, dbc_pkg::DBC_A_CTRL, {29'h0, ctl | 3'h4});
			repeat (40) @(posedge pclk);
			xfer(1'b0, dbc_pkg::DBC_A_STAT, 32'h0);
			check(64'(rd[1]), 64'h0);
			xfer(1'b1, dbc_pkg::DBC_A_CTRL, {29'h0, ctl});
		end
		rd = 32'h0;
		for (int i = 0; i < 30 && rd[1] !== 1'b1; i++) begin
			xfer(1'b0, dbc_pkg::DBC_A_STAT, 32'h0);
		end
		xfer(1'b0, dbc_pkg::DBC_A_DOUT_HI, 32'h0);
		res[63:32] = rd;
		xfer(1'b0, dbc_pkg::DBC_A_DOUT_LO, 32'h0);
		res[31:0] = rd;
	endtask : run

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		tally_and_finish;
	end

	// main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, dbc_pkg::DBC_A_CTRL, 32'h0);
		check(64'(rd), 64'h1);
		xfer(1'b0, dbc_pkg::DBC_A_STAT, 32'h0);
		check(64'(rd), 64'h0);
		xfer(1'b0, 8'h40, 32'h0);
		check({rd, 31'h0, se}, {32'h0, 31'h0, 1'b1});
		run(KEY, PT, 3'h1, 1'b0, q);
		check(q, CT);
		run(KEY, CT, 3'h0, 1'b0, q);
		check(q, PT);
		// pause in both directions
		for (int d = 0; d < 2; d++) begin
			run(KEY, d ? PT : CT, {2'b00, d[0]}, 1'b1, q);
			check(q, d ? CT : PT);
		end
		// bad parity bit must not change the cipher, only the fault flag
		run(KEY_BP, PT, 3'h3, 1'b0, q);
		check(q, CT);
		xfer(1'b0, dbc_pkg::DBC_A_STAT, 32'h0);
		check(64'(rd[2]), 64'h1);
		xfer(1'b1, dbc_pkg::DBC_A_CTRL, 32'h1);
		// the fault passes two flops before it reaches the status word
		repeat (2) @(posedge pclk);
		xfer(1'b0, dbc_pkg::DBC_A_STAT, 32'h0);
		check(64'(rd[2]), 64'h0);
		xfer(1'b1, dbc_pkg::DBC_A_KEY_HI, KEY[63:32]);
		xfer(1'b1, dbc_pkg::DBC_A_CTRL, 32'h3);
		repeat (2) @(posedge pclk);
		xfer(1'b0, dbc_pkg::DBC_A_STAT, 32'h0);
		check(64'(rd[2]), 64'h0);
		// abort mid block, check no result follows within 30 cycles, then restart
		xfer(1'b1, dbc_pkg::DBC_A_STAT, 32'h2);
		xfer(1'b1, dbc_pkg::DBC_A_CMD, 32'h1);
		xfer(1'b1, dbc_pkg::DBC_A_CMD, 32'h2);
		repeat (30) @(posedge pclk);
		xfer(1'b0, dbc_pkg::DBC_A_STAT, 32'h0);
		check(64'(rd[1]), 64'h0);
		run(KEY, PT, 3'h1, 1'b0, q);
		check(q, CT);
		// a second start queued while the first runs: two results, then the gate drops
		n_base = n_res;
		xfer(1'b1, dbc_pkg::DBC_A_CMD, 32'h1);
		xfer(1'b1, dbc_pkg::DBC_A_CMD, 32'h1);
		repeat (60) @(posedge pclk);
		check(64'(n_res - n_base), 64'h2);
		xfer(1'b0, dbc_pkg::DBC_A_STAT, 32'h0);
		check(64'(rd[3:0]), 64'h2);
		xfer(1'b0, dbc_pkg::DBC_A_DOUT_LO, 32'h0);
		check(64'(rd), {32'h0, CT[31:0]});
		tally_and_finish;
	end
endmodule : tb_des_block_cipher
